// ### pkg/emb_params.svh
// constants of the embedded memory block
// What this block does
// - the memory can be set up as dual-port ram, rom, a fifo or a content addressable memory.
// - writes pass through input registers and read data may be pipelined by output registers.
// - in dual-port use a read and a write can happen together, on two different clocks.
// - dual-port use is either read/write clock form or input/output clock form.
// - two ports that each read or write at once are served by combined storage banks.
// - in input/output clock form one clock drives every input register.
// - in input/output clock form a second clock drives only the read data output registers.
// - clock enables and clears act separately on the input side and the output side.
// - every port register clears from a local clear, a global clear or the chip reset; the storage clears only on the chip reset.
// - a single-port form shares one port where read and write never coincide.
// - four clock networks supply the input and output clocks.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_AW 5
`define EMB_DW 8
`define EMB_NET_CNT 4
`define EMB_NET_SEL_W 2
`endif

// ### pkg/emb_pkg.sv
// types of the embedded memory block
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_FUNC_RAM,
    EMB_FUNC_ROM,
    EMB_FUNC_FIFO,
    EMB_FUNC_CAM
  } emb_func_type;
  typedef enum logic [1:0] {
    EMB_CLK_SINGLE,
    EMB_CLK_RW,
    EMB_CLK_IO,
    EMB_CLK_BIDIR
  } emb_clk_mode_type;
endpackage

// ### testbench/emb_memory_block_sva.sv
// assertion checker of the embedded memory block ports
`timescale 1ns/1ns
`default_nettype none
`include "emb_params.svh"
module emb_memory_block_sva #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic in_clr,
  input wire logic out_clr,
  input wire logic global_clr,
  input wire logic a_we,
  input wire logic [DW-1:0] a_rd_data,
  input wire logic [DW-1:0] b_rd_data,
  input wire logic cam_match,
  input wire logic fifo_full,
  input wire logic fifo_empty
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire idle = !(in_ce || out_ce || in_clr || out_clr || global_clr);
  a_rst_values: assert property ($rose(rstn) |-> fifo_empty && !fifo_full && b_rd_data == '0)
    else $error("reset values wrong");
  a_flags_excl: assert property (!(fifo_full && fifo_empty))
    else $error("fifo full and empty together");
  a_gclr_data: assert property (global_clr |=> a_rd_data == '0 && b_rd_data == '0 && !cam_match)
    else $error("global clear left data");
  a_gclr_fifo: assert property (global_clr |=> fifo_empty && !fifo_full)
    else $error("global clear left fifo state");
  a_oclr_data: assert property (out_clr |=> b_rd_data == '0)
    else $error("output clear left data");
  a_ce_hold: assert property (idle [*3] |-> $stable(a_rd_data) && $stable(b_rd_data))
    else $error("data moved with enables low");
  a_empty_push: assert property ($fell(fifo_empty) |-> $past(a_we) || $past(a_we, 2))
    else $error("fifo left empty without push");
  a_full_push: assert property ($rose(fifo_full) |-> $past(a_we) || $past(a_we, 2))
    else $error("fifo full without push");
  cover property ($rose(cam_match));
  cover property ($rose(fifo_full));
  cover property ($fell(fifo_empty));
endmodule
bind emb_memory_block emb_memory_block_sva #(.AW(AW), .DW(DW)) i_emb_memory_block_sva (
  .core_clk, .rstn, .in_ce, .out_ce, .in_clr, .out_clr, .global_clr, .a_we,
  .a_rd_data, .b_rd_data, .cam_match, .fifo_full, .fifo_empty);
`default_nettype wire

// ### testbench/emb_memory_block_tb.sv
// self-checking bench of the embedded memory block
`timescale 1ns/1ns
`default_nettype none
module emb_memory_block_tb;
  logic core_clk = 0, rstn = 0, in_ce = 1, out_ce = 1, o_clr = 0, g_clr = 0, tie0 = 0;
  logic o_reg = 0, a_we = 0, rsa = 0, rsb = 0, i_clr = 0, r_ld = 0, b_we = 0;
  logic [3:0] net;
  logic [1:0] in_sel = 2'h0, out_sel = 2'h1;
  logic [4:0] a_adr = 0, b_adr = 0, ad;
  logic [7:0] a_wd = 0, b_wd = 0, a_rd, b_rd, k;
  logic [7:0] mem [32];
  logic hit, full, empty;
  emb_pkg::emb_func_type fn = emb_pkg::EMB_FUNC_RAM;
  emb_pkg::emb_clk_mode_type md = emb_pkg::EMB_CLK_RW;
  int miscompares = 0, comparisons = 0, cyc_cnt = 0, j;
  emb_net_gen i_emb_net_gen (.core_clk(core_clk), .rstn(rstn), .clk_net(net));
  emb_memory_block i_emb_memory_block (.core_clk(core_clk), .rstn(rstn), .clk_net(net),
    .in_clk_sel(in_sel), .out_clk_sel(out_sel), .cfg_func(fn), .cfg_clk_mode(md),
    .cfg_out_reg(o_reg), .rom_load(r_ld), .in_ce(in_ce), .out_ce(out_ce), .in_clr(i_clr),
    .out_clr(o_clr), .global_clr(g_clr), .a_addr(a_adr), .a_wdata(a_wd), .a_we(a_we),
    .read_strobe_in_a(rsa), .b_addr(b_adr), .b_wdata(b_wd), .b_we(b_we),
    .read_strobe_in_b(rsb), .a_rd_data(a_rd), .b_rd_data(b_rd), .cam_match(hit),
    .fifo_full(full), .fifo_empty(empty));
  always #25 core_clk = ~core_clk;
  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  task cy(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task ck(logic [7:0] g, logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // one input tick falls inside two cycles, one output tick inside four
  task wr(logic [4:0] a, logic [7:0] d);
    a_adr = a;
    a_wd = d;
    a_we = 1;
    cy(2);
    a_we = 0;
    cy(2);
  endtask
  task rd(logic [4:0] a, logic [7:0] key);
    b_adr = a;
    b_wd = key;
    rsb = 1;
    cy(4);
    rsb = 0;
    cy(5);
  endtask
  function logic [4:0] low(logic [7:0] key);
    low = 5'h00;
    for (int i = 31; i >= 0; i--) if (mem[i] == key) low = i[4:0];
  endfunction
  initial begin
    void'($urandom(89611));
    for (j = 0; j < 32; j++) mem[j] = 8'h00;
    cy(16);
    rstn = 1;
    cy(1);
    ck(b_rd, 8'h00);
    ck(empty, 8'h01);
    repeat (12) begin
      ad = $urandom;
      k = $urandom;
      o_reg = $urandom;
      md = emb_pkg::emb_clk_mode_type'($urandom_range(2, 1));
      wr(ad, k);
      mem[ad] = k;
      rd(ad, 8'h00);
      ck(b_rd, k);
    end
    md = emb_pkg::EMB_CLK_RW;
    fn = emb_pkg::EMB_FUNC_CAM;
    rd(5'h00, k);
    ck(b_rd, {3'h0, low(k)});
    ck(hit, 8'h01);
    g_clr = 1;
    cy(1);
    g_clr = 0;
    ck(hit, 8'h00);
    fn = emb_pkg::EMB_FUNC_ROM;
    wr(ad, ~k);
    rd(ad, 8'h00);
    ck(b_rd, k);
    fn = emb_pkg::EMB_FUNC_RAM;
    in_ce = 0;
    out_ce = 0;
    wr(ad, ~k);
    in_ce = 1;
    out_ce = 1;
    rd(ad, 8'h00);
    ck(b_rd, k);
    o_clr = 1;
    cy(1);
    o_clr = 0;
    ck(b_rd, 8'h00);
    fn = emb_pkg::EMB_FUNC_ROM;
    r_ld = 1;
    wr(ad, 8'h5A);
    r_ld = 0;
    rd(ad, 8'h00);
    ck(b_rd, 8'h5A);
    fn = emb_pkg::EMB_FUNC_RAM;
    md = emb_pkg::EMB_CLK_SINGLE;
    wr(ad, 8'hA5);
    rsa = 1;
    cy(2);
    rsa = 0;
    cy(5);
    ck(a_rd, 8'hA5);
    md = emb_pkg::EMB_CLK_BIDIR;
    b_adr = ad;
    b_wd = 8'h3C;
    b_we = 1;
    cy(4);
    b_we = 0;
    cy(2);
    rsa = 1;
    cy(2);
    rsa = 0;
    cy(5);
    ck(a_rd, 8'h3C);
    md = emb_pkg::EMB_CLK_RW;
    fn = emb_pkg::EMB_FUNC_FIFO;
    ck(empty, 8'h01);
    for (j = 0; j < 33; j++) wr(5'h00, j[7:0] + 8'h40);
    ck(full, 8'h01);
    for (j = 0; j < 32; j++) begin
      rd(5'h00, 8'h00);
      ck(b_rd, j[7:0] + 8'h40);
    end
    ck(empty, 8'h01);
    rd(5'h00, 8'h00);
    ck(b_rd, 8'h5F);
    wr(5'h00, 8'h11);
    ck(empty, 8'h00);
    i_clr = 1;
    cy(1);
    i_clr = 0;
    ck(empty, 8'h01);
    finish_test;
  end
endmodule
`default_nettype wire

// ### testbench/emb_net_gen.sv
// user-side model that drives the four clock networks
`timescale 1ns/1ns
`default_nettype none
module emb_net_gen (
  input wire logic core_clk,
  input wire logic rstn,
  output logic [3:0] clk_net
);
  logic [2:0] cnt_q;
  // nets move off the sampling edge; net 0 rises every 2 cycles, net 1 every 4
  always @(negedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign clk_net = {~cnt_q[0], cnt_q};
endmodule
`default_nettype wire

// ### verilog/emb_clk_sel.sv
// picks one clock network and turns its rising edge into a tick
`timescale 1ns/1ns
`default_nettype none
`include "emb_params.svh"
module emb_clk_sel #(
  parameter int N = `EMB_NET_CNT,
  parameter int SW = `EMB_NET_SEL_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [N-1:0] net,
  input wire logic [SW-1:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [N-1:0] prev;
  } emb_sel_state_type;
  emb_sel_state_type s_q;
  emb_sel_state_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.prev = net;
    tick = net[sel] & ~s_q.prev[sel];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/emb_mem_array.sv
// flip-flop storage with two write ports, two read ports and a match search
`timescale 1ns/1ns
`default_nettype none
`include "emb_params.svh"
module emb_mem_array #(
  parameter int AW = `EMB_AW,
  parameter int DW = `EMB_DW
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic wa_en,
  input wire logic [AW-1:0] wa_addr,
  input wire logic [DW-1:0] wa_data,
  input wire logic wb_en,
  input wire logic [AW-1:0] wb_addr,
  input wire logic [DW-1:0] wb_data,
  input wire logic [AW-1:0] ra_addr,
  input wire logic [AW-1:0] rb_addr,
  output logic [DW-1:0] ra_data,
  output logic [DW-1:0] rb_data,
  input wire logic [DW-1:0] cam_key,
  output logic cam_hit,
  output logic [AW-1:0] cam_addr
);
  localparam int DEPTH = 1 << AW;
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
  } emb_arr_state_type;
  emb_arr_state_type s_q;
  emb_arr_state_type s_d;
  logic [DEPTH-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cmp
      assign hit[g] = (s_q.mem[g] == cam_key);
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    if (wb_en) begin
      s_d.mem[wb_addr] = wb_data;
    end
    if (wa_en) begin
      s_d.mem[wa_addr] = wa_data;
    end
    ra_data = s_q.mem[ra_addr];
    rb_data = s_q.mem[rb_addr];
    cam_hit = |hit;
    cam_addr = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (hit[i]) begin
        cam_addr = AW'(i);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ### verilog/emb_memory_block.sv
// embedded memory block: port registers, clocking forms, fifo and match logic
`timescale 1ns/1ns
`default_nettype none
`include "emb_params.svh"
module emb_memory_block #(
  parameter int AW = `EMB_AW,
  parameter int DW = `EMB_DW
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`EMB_NET_CNT-1:0] clk_net,
  input wire logic [`EMB_NET_SEL_W-1:0] in_clk_sel,
  input wire logic [`EMB_NET_SEL_W-1:0] out_clk_sel,
  input wire emb_pkg::emb_func_type cfg_func,
  input wire emb_pkg::emb_clk_mode_type cfg_clk_mode,
  input wire logic cfg_out_reg,
  input wire logic rom_load,
  input wire logic in_ce,
  input wire logic out_ce,
  input wire logic in_clr,
  input wire logic out_clr,
  input wire logic global_clr,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  input wire logic a_we,
  input wire logic read_strobe_in_a,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_wdata,
  input wire logic b_we,
  input wire logic read_strobe_in_b,
  output logic [DW-1:0] a_rd_data,
  output logic [DW-1:0] b_rd_data,
  output logic cam_match,
  output logic fifo_full,
  output logic fifo_empty
);
  localparam int DEPTH = 1 << AW;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] a_addr;
    logic [DW-1:0] a_wd;
    logic a_we;
    logic a_re;
    logic a_go;
    logic a_pend;
    logic [AW-1:0] b_addr;
    logic [DW-1:0] b_wd;
    logic b_we;
    logic b_re;
    logic b_go;
    logic b_pend;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic [DW-1:0] a_rd;
    logic [DW-1:0] b_rd;
    logic match;
    logic full;
    logic empty;
  } emb_core_state_type;

  localparam emb_core_state_type ST_RST = '{empty: 1'b1, default: '0};

  emb_core_state_type s_q;
  emb_core_state_type s_d;

  logic tick_in;
  logic tick_out;
  logic is_single;
  logic is_io;
  logic is_bidir;
  logic is_fifo;
  logic is_cam;
  logic wr_ok;
  logic a_cap;
  logic b_cap;
  logic in_clear;
  logic out_clear;
  logic ma_we;
  logic mb_we;
  logic [AW-1:0] ma_addr;
  logic push;
  logic pop;
  logic a_tick_out;
  logic a_load;
  logic b_load;
  logic [DW-1:0] ra_data;
  logic [DW-1:0] rb_data;
  logic cam_hit;
  logic [AW-1:0] cam_addr;

  emb_clk_sel #(
    .N(`EMB_NET_CNT),
    .SW(`EMB_NET_SEL_W)
  ) u_in_clk (
    .core_clk(core_clk),
    .rstn(rstn),
    .net(clk_net),
    .sel(in_clk_sel),
    .tick(tick_in)
  );

  emb_clk_sel #(
    .N(`EMB_NET_CNT),
    .SW(`EMB_NET_SEL_W)
  ) u_out_clk (
    .core_clk(core_clk),
    .rstn(rstn),
    .net(clk_net),
    .sel(out_clk_sel),
    .tick(tick_out)
  );

  emb_mem_array #(
    .AW(AW),
    .DW(DW)
  ) u_array (
    .core_clk(core_clk),
    .rstn(rstn),
    .wa_en(ma_we),
    .wa_addr(ma_addr),
    .wa_data(s_q.a_wd),
    .wb_en(mb_we),
    .wb_addr(s_q.b_addr),
    .wb_data(s_q.b_wd),
    .ra_addr(s_q.a_addr),
    .rb_addr((is_fifo && !cfg_out_reg) ? s_q.rptr : s_q.b_addr),
    .ra_data(ra_data),
    .rb_data(rb_data),
    .cam_key(s_q.b_wd),
    .cam_hit(cam_hit),
    .cam_addr(cam_addr)
  );

  always_comb begin
    s_d = s_q;
    is_single = (cfg_clk_mode == emb_pkg::EMB_CLK_SINGLE);
    is_io = (cfg_clk_mode == emb_pkg::EMB_CLK_IO);
    is_bidir = (cfg_clk_mode == emb_pkg::EMB_CLK_BIDIR);
    is_fifo = (cfg_func == emb_pkg::EMB_FUNC_FIFO);
    is_cam = (cfg_func == emb_pkg::EMB_FUNC_CAM);
    wr_ok = (cfg_func != emb_pkg::EMB_FUNC_ROM) | rom_load;
    in_clear = in_clr | global_clr;
    out_clear = out_clr | global_clr;
    // input registers: port a on the input clock, port b per clocking form
    a_cap = tick_in & in_ce;
    b_cap = 1'b0;
    if (is_io) begin
      b_cap = tick_in & in_ce;
    end else if (!is_single) begin
      b_cap = tick_out & in_ce;
    end
    s_d.a_go = a_cap;
    s_d.b_go = b_cap;
    if (a_cap) begin
      s_d.a_addr = a_addr;
      s_d.a_wd = a_wdata;
      s_d.a_we = a_we;
      s_d.a_re = read_strobe_in_a & ~(is_single & a_we);
    end
    if (b_cap) begin
      s_d.b_addr = b_addr;
      s_d.b_wd = b_wdata;
      s_d.b_we = b_we & is_bidir;
      s_d.b_re = read_strobe_in_b;
    end
    // storage writes come only from registered strobes
    ma_addr = is_fifo ? s_q.wptr : s_q.a_addr;
    ma_we = s_q.a_go & s_q.a_we & wr_ok & ~(is_fifo & s_q.full);
    mb_we = s_q.b_go & s_q.b_we & is_bidir & wr_ok & ~is_fifo;
    push = is_fifo & ma_we;
    pop = is_fifo & s_q.b_go & s_q.b_re & ~s_q.empty;
    if (push) begin
      s_d.wptr = s_q.wptr + 1'b1;
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + 1'b1;
      s_d.b_addr = s_q.rptr;
    end
    if (push & ~pop) begin
      s_d.count = s_q.count + 1'b1;
    end else if (pop & ~push) begin
      s_d.count = s_q.count - 1'b1;
    end
    s_d.full = (s_d.count == FULL_CNT);
    s_d.empty = (s_d.count == '0);
    // output side: port a uses the input clock, port b the output clock
    a_tick_out = tick_in & out_ce & (is_single | is_bidir);
    if (s_q.a_go & s_q.a_re & (is_single | is_bidir)) begin
      s_d.a_pend = 1'b1;
    end
    if (s_q.b_go & s_q.b_re & (~is_fifo | ~s_q.empty) & ~is_single) begin
      s_d.b_pend = 1'b1;
    end
    if (cfg_out_reg) begin
      a_load = s_q.a_pend & a_tick_out;
      b_load = s_q.b_pend & tick_out & out_ce;
    end else begin
      a_load = s_q.a_go & s_q.a_re & (is_single | is_bidir);
      b_load = s_q.b_go & s_q.b_re & ~is_single & (~is_fifo | ~s_q.empty);
    end
    if (a_load) begin
      s_d.a_rd = ra_data;
      s_d.a_pend = 1'b0;
    end
    if (b_load) begin
      s_d.b_pend = 1'b0;
      if (is_cam) begin
        s_d.b_rd = DW'(cam_addr);
        s_d.match = cam_hit;
      end else begin
        s_d.b_rd = rb_data;
      end
    end
    if (in_clear) begin
      s_d.a_addr = '0;
      s_d.a_wd = '0;
      s_d.a_we = 1'b0;
      s_d.a_re = 1'b0;
      s_d.a_go = 1'b0;
      s_d.b_addr = '0;
      s_d.b_wd = '0;
      s_d.b_we = 1'b0;
      s_d.b_re = 1'b0;
      s_d.b_go = 1'b0;
      s_d.wptr = '0;
      s_d.rptr = '0;
      s_d.count = '0;
      s_d.full = 1'b0;
      s_d.empty = 1'b1;
    end
    if (out_clear) begin
      s_d.a_rd = '0;
      s_d.b_rd = '0;
      s_d.match = 1'b0;
      s_d.a_pend = 1'b0;
      s_d.b_pend = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign a_rd_data = s_q.a_rd;
  assign b_rd_data = s_q.b_rd;
  assign cam_match = s_q.match;
  assign fifo_full = s_q.full;
  assign fifo_empty = s_q.empty;
endmodule
`default_nettype wire
